// file: pkg/stec_cfg.svh
// Purpose: Constants for the scan timer and event counter block.
// Assumes: A 20 MHz processing clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef STEC_CFG_SVH
`define STEC_CFG_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define STEC_CLK_HZ 20000000
`define STEC_TIME_UNIT_MS 100
`define STEC_TICK_CYCLES ((`STEC_CLK_HZ / 1000) * `STEC_TIME_UNIT_MS)

// ==========================================================================
// Widths, counts and reset values
// ==========================================================================
`define STEC_NUM_TMR 80
`define STEC_NUM_CNT 40
`define STEC_VAL_W 16
`define STEC_CONST_W 15
`define STEC_CUR_RST 16'h0000
`define STEC_SET_ONE 16'h0001

`endif

// file: pkg/stec_pkg.sv
// Purpose: Types shared by the scan timer and event counter block.
// Assumes: The constants header is on the include path.
// Notes: The set value selector carries both possible sources.
`include "stec_cfg.svh"

package stec_pkg;

  // ========================================================================
  // Set value selector
  // ========================================================================
  typedef struct packed {
    logic use_reg;
    logic [`STEC_CONST_W-1:0] const_val;
    logic [`STEC_VAL_W-1:0] reg_val;
  } stec_setsel_t;

  typedef logic signed [`STEC_VAL_W-1:0] stec_val_t;

  // A constant has no sign bit, so it is always zero-extended as positive.
  function automatic stec_val_t stec_eff_set(input stec_setsel_t sel);
    stec_val_t v;
    v = sel.use_reg ? stec_val_t'(sel.reg_val) : stec_val_t'({1'b0, sel.const_val});
    return v;
  endfunction : stec_eff_set

endpackage : stec_pkg

// file: verilog/stec_cnt_chan.sv
// Purpose: One sixteen-bit event counter channel.
// Assumes: scan_end is a one-cycle pulse marking the end of a program scan.
// Notes: All counting work is done at scan_end so that contacts change between scans.
`timescale 1ns/1ns
`default_nettype none
`include "stec_cfg.svh"

module stec_cnt_chan
  import stec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scan_end,
  input wire logic count_in,
  input wire logic clear,
  input wire logic load,
  input wire stec_val_t load_val,
  input wire stec_setsel_t set_sel,
  output stec_val_t cur_reg,
  output logic contact_reg
);

  logic prev_in_reg;
  logic edge_seen;
  stec_val_t set_val;
  stec_val_t cur_next;
  logic contact_next;

  assign edge_seen = count_in & ~prev_in_reg;

  always_comb begin
    set_val = stec_eff_set(set_sel);
    if (set_val == stec_val_t'(0)) begin
      set_val = stec_val_t'(`STEC_SET_ONE);
    end
  end

  always_comb begin
    cur_next = cur_reg;
    contact_next = contact_reg;
    if (clear) begin
      cur_next = stec_val_t'(`STEC_CUR_RST);
      contact_next = 1'b0;
    end else if (load) begin
      cur_next = load_val;
    end else if (edge_seen && !contact_reg) begin
      // An edge at or past the set value lands on it, so the count never runs beyond.
      if (cur_reg >= set_val) begin
        cur_next = set_val;
        contact_next = 1'b1;
      end else begin
        cur_next = cur_reg + stec_val_t'(1);
        contact_next = (cur_next == set_val);
      end
    end
  end

  // Input history is kept per scan, not per clock, so one scan sees one edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_in_reg <= 1'b0;
    end else if (scan_end) begin
      prev_in_reg <= count_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= stec_val_t'(`STEC_CUR_RST);
      contact_reg <= 1'b0;
    end else if (scan_end) begin
      cur_reg <= cur_next;
      contact_reg <= contact_next;
    end
  end

endmodule : stec_cnt_chan

`default_nettype wire

// file: verilog/stec_top.sv
// Purpose: Event counters and timer contacts evaluated once per program scan; timer values step on the time-unit tick.
// Assumes: Inputs are synchronous to core_clk; scan_end pulses once per scan.
// Notes: Timers share one time-unit tick; counters are separate channel instances.
// ==========================================================================
`timescale 1ns/1ns
`default_nettype none
`include "stec_cfg.svh"

module stec_top
  import stec_pkg::*;
#(
  parameter int NUM_TMR = `STEC_NUM_TMR,
  parameter int NUM_CNT = `STEC_NUM_CNT,
  parameter int TICK_CYCLES = `STEC_TICK_CYCLES
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scan_end,
  input wire logic [NUM_TMR-1:0] tmr_drive,
  input wire stec_setsel_t [NUM_TMR-1:0] tmr_set,
  input wire logic [NUM_CNT-1:0] counting_input_contact,
  input wire logic [NUM_CNT-1:0] cnt_clear,
  input wire logic [NUM_CNT-1:0] cnt_load,
  input wire stec_val_t cnt_load_val,
  input wire stec_setsel_t [NUM_CNT-1:0] cnt_set,
  output logic [NUM_TMR-1:0] tmr_contact_reg,
  output stec_val_t [NUM_TMR-1:0] tmr_cur_reg,
  output logic [NUM_CNT-1:0] cnt_contact_reg,
  output stec_val_t [NUM_CNT-1:0] cnt_cur_reg
);

  // ========================================================================
  // Reset release
  // ========================================================================
  // Reset takes hold at once but leaves on a clock edge, so no flop sees a
  // release in the middle of a cycle.
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ========================================================================
  // Time-unit tick
  // ========================================================================
  // One shared free-running tick keeps all timers aligned; the cost is that a
  // timer's first step may come up to one unit early after it is driven.
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;

  // True on the last cycle of a time unit, so the tick flop fires once per unit.
  function automatic logic tick_is_last(
    input logic [TICK_W-1:0] cnt_v
  );
    logic last;
    last = (cnt_v == TICK_LAST);
    return last;
  endfunction : tick_is_last

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_is_last(tick_cnt_reg)) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Timer decoding
  // ========================================================================
  // The step test is unsigned on purpose: a negative set value read from a
  // data register then reads as a long delay rather than an instant expiry.
  function automatic logic tmr_may_step(
    input stec_val_t cur_v,
    input stec_val_t set_v
  );
    logic ok;
    if ($unsigned(cur_v) < $unsigned(set_v)) begin
      ok = 1'b1;
    end else begin
      ok = 1'b0;
    end
    return ok;
  endfunction : tmr_may_step

  // Next current value of one timer from its drive, the tick and its set value.
  function automatic stec_val_t tmr_next_val(
    input logic drive_v,
    input logic tick_v,
    input stec_val_t cur_v,
    input stec_val_t set_v
  );
    stec_val_t nxt;
    nxt = cur_v;
    if (!drive_v) begin
      nxt = stec_val_t'(`STEC_CUR_RST);
    end else if (tick_v && tmr_may_step(cur_v, set_v)) begin
      nxt = cur_v + stec_val_t'(1);
    end
    return nxt;
  endfunction : tmr_next_val

  // A timer has expired while it is driven and its value equals the set value.
  function automatic logic tmr_expired(
    input logic drive_v,
    input stec_val_t cur_v,
    input stec_val_t set_v
  );
    logic hit;
    if (drive_v && (cur_v == set_v)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction : tmr_expired

  // ========================================================================
  // Timers
  // ========================================================================
  genvar gt;
  generate
    for (gt = 0; gt < NUM_TMR; gt++) begin : g_tmr
      stec_val_t set_val;
      stec_val_t cur_next;
      logic done_reg;

      // Set value counts time units, so the delay is set value times the unit.
      assign set_val = stec_eff_set(tmr_set[gt]);

      always_comb begin
        cur_next = tmr_next_val(tmr_drive[gt], tick_reg, tmr_cur_reg[gt], set_val);
      end

      always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          tmr_cur_reg[gt] <= stec_val_t'(`STEC_CUR_RST);
        end else begin
          tmr_cur_reg[gt] <= cur_next;
        end
      end

      // Expiry is judged on the value being written, so done follows cur at once.
      always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          done_reg <= 1'b0;
        end else begin
          done_reg <= tmr_expired(tmr_drive[gt], cur_next, set_val);
        end
      end

      // The contact seen by the program is taken only at the scan boundary.
      always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          tmr_contact_reg[gt] <= 1'b0;
        end else if (scan_end) begin
          tmr_contact_reg[gt] <= done_reg;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Counters
  // ========================================================================
  // Indirect set values are trusted as given; screening special registers is
  // the program's job.
  // The load value bus is shared; only channels whose load bit is set take it.
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CNT; gc++) begin : g_cnt
      stec_cnt_chan u_chan (
        .core_clk(core_clk),
        .rst_n(rst_n_reg),
        .scan_end(scan_end),
        .count_in(counting_input_contact[gc]),
        .clear(cnt_clear[gc]),
        .load(cnt_load[gc]),
        .load_val(cnt_load_val),
        .set_sel(cnt_set[gc]),
        .cur_reg(cnt_cur_reg[gc]),
        .contact_reg(cnt_contact_reg[gc])
      );
    end
  endgenerate

endmodule : stec_top

`default_nettype wire

// file: bench/stec_checker.sv
// Purpose: Port assertions for stec_top.
// Assumes: Channel 0 of each kind stands for all.
// Notes: Set value decoding is redone here.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Checker
module stec_checker
  import stec_pkg::*;
#(parameter int NUM_TMR = 1, parameter int NUM_CNT = 1, parameter int TICK_CYCLES = 4)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scan_end,
  input wire logic [NUM_TMR-1:0] tmr_drive,
  input wire stec_setsel_t [NUM_TMR-1:0] tmr_set,
  input wire logic [NUM_CNT-1:0] counting_input_contact,
  input wire logic [NUM_CNT-1:0] cnt_clear,
  input wire logic [NUM_CNT-1:0] cnt_load,
  input wire stec_val_t cnt_load_val,
  input wire stec_setsel_t [NUM_CNT-1:0] cnt_set,
  input wire logic [NUM_TMR-1:0] tmr_contact_reg,
  input wire stec_val_t [NUM_TMR-1:0] tmr_cur_reg,
  input wire logic [NUM_CNT-1:0] cnt_contact_reg,
  input wire stec_val_t [NUM_CNT-1:0] cnt_cur_reg
);
  logic prev_reg;
  stec_val_t cs;
  stec_val_t c;
  stec_val_t t;
  logic q;
  logic e;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) prev_reg <= 1'b0;
    else if (scan_end) prev_reg <= counting_input_contact[0];
  end
  // A zero set value must act as one, so it is folded here once.
  always_comb begin
    cs = cnt_set[0].use_reg ? cnt_set[0].reg_val : {1'b0, cnt_set[0].const_val};
    if (cs == 16'sh0000) cs = 16'sh0001;
  end
  assign c = cnt_cur_reg[0];
  assign t = tmr_cur_reg[0];
  assign q = scan_end && !cnt_clear[0] && !cnt_load[0];
  assign e = counting_input_contact[0] && !prev_reg;
  a_cnt_quiet: assert property (!scan_end |=> $stable(c) && $stable(cnt_contact_reg))
    else $error("counter moved off scan");
  a_tmr_quiet: assert property (!scan_end |=> $stable(tmr_contact_reg))
    else $error("timer contact moved off scan");
  a_cnt_clear: assert property (scan_end && cnt_clear[0] |=> c == 0 && !cnt_contact_reg[0])
    else $error("clear failed");
  a_cnt_step: assert property (q && e && !cnt_contact_reg[0] && c < cs - 1 |=> c == $past(c) + 1)
    else $error("count step wrong");
  a_cnt_reach: assert property (q && e && !cnt_contact_reg[0] && c >= cs - 1 |=>
    c == cs && cnt_contact_reg[0]) else $error("count end wrong");
  a_cnt_hold: assert property (q && cnt_contact_reg[0] |=> $stable(c) && cnt_contact_reg[0])
    else $error("counter left set value");
  a_tmr_step: assert property (tmr_drive[0] && $past(tmr_drive[0]) && $changed(t) |->
    t == stec_val_t'($past(t) + 1) ##1 ($stable(t) || !$past(tmr_drive[0])) [*3])
    else $error("timer step wrong");
  a_tmr_on: assert property ((tmr_drive[0] && t == tmr_set[0].reg_val && tmr_set[0].use_reg)
    ##1 (tmr_drive[0] && scan_end) |=> tmr_contact_reg[0]) else $error("timer contact late");
  a_tmr_drop: assert property (!tmr_drive[0] |=> t == 0) else $error("timer not cleared");
endmodule : stec_checker

bind stec_top stec_checker #(.NUM_TMR(NUM_TMR), .NUM_CNT(NUM_CNT), .TICK_CYCLES(TICK_CYCLES)) i_chk (.*);
`default_nettype wire

// file: bench/stec_scan_model.sv
// Purpose: Program scan source for stec_top.
// Assumes: gap is at least 2.
// Notes: One scan end pulse every gap plus one cycles.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Scan model
module stec_scan_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [3:0] gap,
  output logic scan_end
);
  logic [3:0] cnt_reg;
  // Contacts may only change at this pulse.
  always_ff @(posedge core_clk) begin
    cnt_reg <= (!run || cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
    scan_end <= run && cnt_reg >= gap;
  end
endmodule : stec_scan_model
`default_nettype wire

// file: bench/scan_timer_event_counter_tb.sv
// Purpose: Self-checking bench for stec_top.
// Assumes: One channel of each kind, tick of 4 cycles.
// Notes: Counter state is predicted scan by scan.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Bench
module scan_timer_event_counter_tb;
  import stec_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  logic [3:0] gap = 4'h2;
  logic scan_end;
  logic tdrv = 1'b0;
  stec_setsel_t tset = '0;
  logic cin = 1'b0;
  logic clr = 1'b0;
  logic ld = 1'b0;
  stec_val_t lval = '0;
  stec_setsel_t cset = '0;
  logic tcon;
  stec_val_t tcur;
  logic ccon;
  stec_val_t ccur;
  int num_errors = 0;
  int compares = 0;
  int ts;
  logic p;
  logic [16:0] st;
  logic [15:0] lf = 16'h0053;
  // Selector words: entries 0, 1 and 3 give constant set values, only entry 2 an indirect one.
  logic [31:0] sets [4] = '{32'h0005_0002, 32'h0000_0003, 32'h8009_fffd, 32'h7fff_0001};
  stec_top #(.NUM_TMR(1), .NUM_CNT(1), .TICK_CYCLES(4)) i_dut (.core_clk(core_clk),
    .rstn(rstn), .scan_end(scan_end), .tmr_drive(tdrv), .tmr_set(tset),
    .counting_input_contact(cin), .cnt_clear(clr), .cnt_load(ld), .cnt_load_val(lval),
    .cnt_set(cset), .tmr_contact_reg(tcon), .tmr_cur_reg(tcur), .cnt_contact_reg(ccon),
    .cnt_cur_reg(ccur));
  stec_scan_model i_scan (.core_clk(core_clk), .run(run), .gap(gap), .scan_end(scan_end));
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic logic [16:0] cnt_exp(input logic [16:0] s0, input logic pv);
    int s;
    s = cset.use_reg ? int'($signed(cset.reg_val)) : int'(cset.const_val);
    if (s == 0) s = 1;
    if (clr) return 17'h0_0000;
    if (ld) return {s0[16], lval};
    if (!cin || pv || s0[16]) return s0;
    if (int'($signed(s0[15:0])) + 1 >= s) return {1'b1, 16'(s)};
    return {1'b0, s0[15:0] + 16'h0001};
  endfunction : cnt_exp
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h saw %h", n, x, s);
    end
  endtask : chk
  task automatic scan();
    do @(posedge core_clk); while (scan_end !== 1'b1);
    #1;
  endtask : scan
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    run <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      @(posedge core_clk);
      cset <= sets[t];
      clr <= 1'b1;
      scan();
      st = 17'h0_0000;
      p = cin;
      for (int i = 0; i < 30; i++) begin
        @(posedge core_clk);
        lf = lfsr(lf);
        cin <= lf[0];
        clr <= lf[3:1] == 3'h0;
        // Loads stay off while the contact is on, where their effect is left open.
        ld <= !st[16] && lf[6:4] == 3'h0;
        lval <= t == 3 ? lf : {12'h000, lf[11:8]};
        gap <= 4'h2 + {1'b0, lf[14:12]};
        scan();
        st = cnt_exp(st, p);
        p = cin;
        chk("cnt_cur", ccur, st[15:0]);
        chk("cnt_con", {15'h0000, ccon}, {15'h0000, st[16]});
      end
      $display("counter set %0d done", t);
    end
    for (int t = 0; t < 3; t++) begin
      @(posedge core_clk);
      lf = lfsr(lf);
      ts = 1 + lf[1:0];
      tset <= lf[2] ? {1'b1, 15'h0007, 16'(ts)} : {1'b0, 15'(ts), 16'h0007};
      tdrv <= 1'b1;
      repeat (4 * ts + 8) @(posedge core_clk);
      scan();
      scan();
      chk("tmr_cur", tcur, 16'(ts));
      chk("tmr_con", {15'h0000, tcon}, 16'h0001);
      @(posedge core_clk);
      tdrv <= 1'b0;
      scan();
      scan();
      chk("tmr_off", {tcur[14:0], tcon}, 16'h0000);
      $display("timer run %0d done", t);
    end
    give_verdict();
  end
endmodule : scan_timer_event_counter_tb
`default_nettype wire
